// *** rtl/capture_params.svh ***
`ifndef CAPTURE_PARAMS_SVH
`define CAPTURE_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_CONTROL       8'h00
`define OFF_TIMER_SELECT  8'h04
`define OFF_CAPTURE       8'h08
`define OFF_COMPARE       8'h0c
`define OFF_STATUS        8'h10
`define OFF_MASK          8'h14

// ****************************************
// Field positions
// ****************************************
`define CTRL_EN_BIT       7
`define CTRL_OUT_BIT      5
`define CTRL_MODE_MSB     3
`define CTRL_MODE_LSB     0
`define TSEL_UNIT_ONE_MSB 1
`define TSEL_UNIT_ONE_LSB 0
`define STAT_FLAG_BIT     0

// ****************************************
// Reset values
// ****************************************
`define RST_CONTROL       8'h00
`define RST_TIMER_SELECT  8'h55
`define RST_COMPARE       16'h0000
`define RST_CAPTURE       16'h0000
`define RST_STATUS        1'b0
`define RST_MASK          1'b0

// ****************************************
// Edge counts and bus answers
// ****************************************
`define DIV_FOUR          5'd4
`define DIV_SIXTEEN       5'd16
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// *** rtl/capture_compare_pkg.sv ***
package capture_compare_pkg;

    typedef enum logic [3:0] {
        MODE_OFF        = 4'b0000,
        MODE_TOGGLE_CLR = 4'b0001,
        MODE_TOGGLE     = 4'b0010,
        MODE_CAP_ANY    = 4'b0011,
        MODE_CAP_FALL   = 4'b0100,
        MODE_CAP_RISE   = 4'b0101,
        MODE_CAP_DIV4   = 4'b0110,
        MODE_CAP_DIV16  = 4'b0111,
        MODE_SET        = 4'b1000,
        MODE_CLEAR      = 4'b1001,
        MODE_PULSE      = 4'b1010,
        MODE_PULSE_CLR  = 4'b1011,
        MODE_PWM_0      = 4'b1100,
        MODE_PWM_1      = 4'b1101,
        MODE_PWM_2      = 4'b1110,
        MODE_PWM_3      = 4'b1111
    } mode_e;

    typedef enum logic [1:0] {
        TIMER_RESERVED = 2'b00,
        TIMER_DEFAULT  = 2'b01,
        TIMER_THREE    = 2'b10,
        TIMER_FIVE     = 2'b11
    } timer_choice_e;

    typedef logic [15:0] timer_value_t;

endpackage : capture_compare_pkg

// *** rtl/pin_edge_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Three-stage pin synchroniser with edge pulses
// ****************************************
module pin_edge_sync (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);
    logic stage1;
    logic stage2;
    logic stage3;
    logic stable;
    logic next_stable;
    logic next_rise;
    logic next_fall;

    // Change counts once stages two and three agree
    always_comb begin
        next_stable = stable;
        next_rise   = 1'b0;
        next_fall   = 1'b0;
        if (stage2 == stage3 && stage3 != stable) begin
            next_stable = stage3;
            next_rise   = stage3;
            next_fall   = ~stage3;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            stable <= 1'b0;
            rise   <= 1'b0;
            fall   <= 1'b0;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            stable <= next_stable;
            rise   <= next_rise;
            fall   <= next_fall;
        end
    end

endmodule : pin_edge_sync

`default_nettype wire

// *** rtl/edge_divider.sv ***
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Counts edges, ticks on every n-th one
// ****************************************
module edge_divider #(
    parameter int WIDTH = 5
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             restart,
    input  wire logic             edge_in,
    input  wire logic [WIDTH-1:0] divisor,
    output logic                  tick
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic             next_tick;

    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (restart) begin
            next_count = '0;
        end else if (edge_in) begin
            if (count + 1'b1 == divisor) begin
                next_count = '0;
                next_tick  = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end

endmodule : edge_divider

`default_nettype wire

// *** rtl/capture_compare_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "capture_params.svh"

// What this block does
// - Capture and flag on any, falling, rising edge
// - Capture on every fourth or sixteenth rise
// - Toggle output on match; 0001 clears timer
// - Set or clear output on match, flag
// - Pulse output on match; 1011 clears timer
// - Mode zero or disable returns output low
// - Clear the currently selected timer, not default
module capture_compare_unit #(
    parameter int ADDR_W = 8
) (
    input  wire logic                              aclk,
    input  wire logic                              aresetn,
    input  wire logic [ADDR_W-1:0]                 s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [ADDR_W-1:0]                 s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [31:0]                            s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    input  wire logic                              capture_input_pin,
    input  wire capture_compare_pkg::timer_value_t default_timer_value,
    input  wire capture_compare_pkg::timer_value_t timer_three_value,
    input  wire capture_compare_pkg::timer_value_t timer_five_value,
    output logic                                   compare_output,
    output logic                                   clear_default_timer,
    output logic                                   clear_timer_three,
    output logic                                   clear_timer_five,
    output logic                                   irq
);
    import capture_compare_pkg::*;

    localparam logic [2:0] IDX_CONTROL = 3'd0;
    localparam logic [2:0] IDX_TSEL    = 3'd1;
    localparam logic [2:0] IDX_CAPTURE = 3'd2;
    localparam logic [2:0] IDX_COMPARE = 3'd3;
    localparam logic [2:0] IDX_STATUS  = 3'd4;
    localparam logic [2:0] IDX_MASK    = 3'd5;
    localparam logic [2:0] IDX_NONE    = 3'd7;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] addr);
        logic [7:0] a;
        a = 8'(addr);
        case (a)
            `OFF_CONTROL:      reg_index = IDX_CONTROL;
            `OFF_TIMER_SELECT: reg_index = IDX_TSEL;
            `OFF_CAPTURE:      reg_index = IDX_CAPTURE;
            `OFF_COMPARE:      reg_index = IDX_COMPARE;
            `OFF_STATUS:       reg_index = IDX_STATUS;
            `OFF_MASK:         reg_index = IDX_MASK;
            default:           reg_index = IDX_NONE;
        endcase
    endfunction : reg_index

    function automatic logic [7:0] merge_byte(input logic [7:0] old_value,
                                              input logic [7:0] new_value,
                                              input logic       lane);
        merge_byte = lane ? new_value : old_value;
    endfunction : merge_byte

    // ****************************************
    // State
    // ****************************************
    logic [ADDR_W-1:0] aw_addr;
    logic              aw_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              w_held;
    logic              unit_enable;
    mode_e             mode;
    logic [7:0]        unit_timer_select;
    timer_value_t      compare_value;
    timer_value_t      captured_value;
    logic              unit_interrupt_flag;
    logic              flag_mask;
    logic              match_prev;

    logic [ADDR_W-1:0] next_aw_addr;
    logic              next_aw_held;
    logic [31:0]       next_w_data;
    logic [3:0]        next_w_strb;
    logic              next_w_held;
    logic              next_awready;
    logic              next_wready;
    logic [1:0]        next_bresp;
    logic              next_bvalid;
    logic              next_arready;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;
    logic              next_rvalid;
    logic              next_unit_enable;
    mode_e             next_mode;
    logic [7:0]        next_unit_timer_select;
    timer_value_t      next_compare_value;
    timer_value_t      next_captured_value;
    logic              next_unit_interrupt_flag;
    logic              next_flag_mask;
    logic              next_match_prev;
    logic              next_compare_output;
    logic              next_clear_default;
    logic              next_clear_three;
    logic              next_clear_five;
    logic              next_irq;

    logic              do_write;
    logic [2:0]        write_index;
    logic              control_write;
    logic              pin_rise;
    logic              pin_fall;
    logic              div_tick;
    logic [4:0]        divisor;
    timer_choice_e     unit_one_timer_choice;
    timer_value_t      selected_timer;
    logic              match_now;
    logic              match_rise;
    logic              capture_event;
    logic              unit_event;
    logic              clears_timer;

    // ****************************************
    // Input edge path
    // ****************************************
    pin_edge_sync u_pin_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (capture_input_pin),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    assign divisor = (mode == MODE_CAP_DIV16) ? `DIV_SIXTEEN : `DIV_FOUR;

    edge_divider #(
        .WIDTH (5)
    ) u_divider (
        .aclk    (aclk),
        .aresetn (aresetn),
        .restart (control_write),
        .edge_in (pin_rise),
        .divisor (divisor),
        .tick    (div_tick)
    );

    // ****************************************
    // Timer selection and match
    // ****************************************
    assign unit_one_timer_choice =
        timer_choice_e'(unit_timer_select[`TSEL_UNIT_ONE_MSB:`TSEL_UNIT_ONE_LSB]);

    always_comb begin
        case (unit_one_timer_choice)
            TIMER_THREE: selected_timer = timer_three_value;
            TIMER_FIVE:  selected_timer = timer_five_value;
            default:     selected_timer = default_timer_value;
        endcase
    end

    assign match_now  = unit_enable && (selected_timer == compare_value);
    assign match_rise = match_now && !match_prev;

    // ****************************************
    // Bus write and read handshake
    // ****************************************
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign write_index   = reg_index(aw_addr);
    assign control_write = do_write && write_index == IDX_CONTROL;

    always_comb begin
        next_aw_addr = aw_addr;
        next_aw_held = aw_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_w_held  = w_held;
        next_bresp   = s_axi_bresp;
        next_bvalid  = s_axi_bvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        next_rvalid  = s_axi_rvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_addr = s_axi_awaddr;
            next_aw_held = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
            next_w_held = 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (write_index == IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = `RESP_OKAY;
            case (reg_index(s_axi_araddr))
                IDX_CONTROL: next_rdata = {24'h000000, unit_enable, 1'b0, compare_output,
                                           1'b0, mode};
                IDX_TSEL:    next_rdata = {24'h000000, unit_timer_select};
                IDX_CAPTURE: next_rdata = {16'h0000, captured_value};
                IDX_COMPARE: next_rdata = {16'h0000, compare_value};
                IDX_STATUS:  next_rdata = {31'h00000000, unit_interrupt_flag};
                IDX_MASK:    next_rdata = {31'h00000000, flag_mask};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = `RESP_SLVERR;
                end
            endcase
        end
        next_awready = !next_aw_held;
        next_wready  = !next_w_held;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr       <= '0;
            aw_held       <= 1'b0;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bresp   <= `RESP_OKAY;
            s_axi_bvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
        end else begin
            aw_addr       <= next_aw_addr;
            aw_held       <= next_aw_held;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            w_held        <= next_w_held;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bresp   <= next_bresp;
            s_axi_bvalid  <= next_bvalid;
            s_axi_arready <= next_arready;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
            s_axi_rvalid  <= next_rvalid;
        end
    end

    // ****************************************
    // Mode behaviour and registers
    // ****************************************
    always_comb begin
        capture_event = 1'b0;
        case (mode)
            MODE_CAP_ANY:   capture_event = pin_rise || pin_fall;
            MODE_CAP_FALL:  capture_event = pin_fall;
            MODE_CAP_RISE:  capture_event = pin_rise;
            MODE_CAP_DIV4:  capture_event = div_tick;
            MODE_CAP_DIV16: capture_event = div_tick;
            default:        capture_event = 1'b0;
        endcase
        capture_event = capture_event && unit_enable;
    end

    always_comb begin
        next_compare_output = compare_output;
        unit_event          = 1'b0;
        if (!unit_enable) begin
            next_compare_output = 1'b0;
        end else begin
            case (mode)
                MODE_OFF: begin
                    next_compare_output = 1'b0;
                end
                MODE_TOGGLE, MODE_TOGGLE_CLR: begin
                    next_compare_output = compare_output ^ match_rise;
                    unit_event          = match_rise;
                end
                MODE_SET: begin
                    next_compare_output = compare_output || match_rise;
                    unit_event          = match_rise;
                end
                MODE_CLEAR: begin
                    next_compare_output = compare_output && !match_rise;
                    unit_event          = match_rise;
                end
                MODE_PULSE, MODE_PULSE_CLR: begin
                    next_compare_output = match_rise;
                    unit_event          = match_rise;
                end
                MODE_PWM_0, MODE_PWM_1, MODE_PWM_2, MODE_PWM_3: begin
                    next_compare_output = selected_timer < compare_value;
                    unit_event          = match_rise;
                end
                default: begin
                    next_compare_output = 1'b0;
                    unit_event          = capture_event;
                end
            endcase
        end
    end

    // Timer clear follows the live selection
    assign clears_timer = match_rise &&
                          (mode == MODE_TOGGLE_CLR || mode == MODE_PULSE_CLR);

    always_comb begin
        next_unit_enable       = unit_enable;
        next_mode              = mode;
        next_unit_timer_select = unit_timer_select;
        next_compare_value     = compare_value;
        next_flag_mask         = flag_mask;
        next_captured_value    = captured_value;
        next_unit_interrupt_flag = unit_interrupt_flag;
        if (do_write) begin
            case (write_index)
                IDX_CONTROL: begin
                    if (w_strb[0]) begin
                        next_unit_enable = w_data[`CTRL_EN_BIT];
                        next_mode = mode_e'(w_data[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
                    end
                end
                IDX_TSEL: begin
                    next_unit_timer_select = merge_byte(unit_timer_select, w_data[7:0],
                                                        w_strb[0]);
                end
                IDX_COMPARE: begin
                    next_compare_value = {merge_byte(compare_value[15:8], w_data[15:8],
                                                     w_strb[1]),
                                          merge_byte(compare_value[7:0], w_data[7:0],
                                                     w_strb[0])};
                end
                IDX_STATUS: begin
                    if (w_strb[0] && w_data[`STAT_FLAG_BIT]) begin
                        next_unit_interrupt_flag = 1'b0;
                    end
                end
                IDX_MASK: begin
                    if (w_strb[0]) begin
                        next_flag_mask = w_data[0];
                    end
                end
                default: begin
                    next_flag_mask = flag_mask;
                end
            endcase
        end
        if (capture_event) begin
            next_captured_value = selected_timer;
        end
        // Event wins over a clear in the same cycle
        if (unit_event) begin
            next_unit_interrupt_flag = 1'b1;
        end
        next_match_prev    = match_now;
        next_clear_default = clears_timer && unit_one_timer_choice != TIMER_THREE
                             && unit_one_timer_choice != TIMER_FIVE;
        next_clear_three   = clears_timer && unit_one_timer_choice == TIMER_THREE;
        next_clear_five    = clears_timer && unit_one_timer_choice == TIMER_FIVE;
        next_irq           = next_unit_interrupt_flag && next_flag_mask;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unit_enable         <= 1'(`RST_CONTROL >> `CTRL_EN_BIT);
            mode                <= MODE_OFF;
            unit_timer_select   <= `RST_TIMER_SELECT;
            compare_value       <= `RST_COMPARE;
            captured_value      <= `RST_CAPTURE;
            unit_interrupt_flag <= `RST_STATUS;
            flag_mask           <= `RST_MASK;
            match_prev          <= 1'b0;
            compare_output      <= 1'b0;
            clear_default_timer <= 1'b0;
            clear_timer_three   <= 1'b0;
            clear_timer_five    <= 1'b0;
            irq                 <= 1'b0;
        end else begin
            unit_enable         <= next_unit_enable;
            mode                <= next_mode;
            unit_timer_select   <= next_unit_timer_select;
            compare_value       <= next_compare_value;
            captured_value      <= next_captured_value;
            unit_interrupt_flag <= next_unit_interrupt_flag;
            flag_mask           <= next_flag_mask;
            match_prev          <= next_match_prev;
            compare_output      <= next_compare_output;
            clear_default_timer <= next_clear_default;
            clear_timer_three   <= next_clear_three;
            clear_timer_five    <= next_clear_five;
            irq                 <= next_irq;
        end
    end

endmodule : capture_compare_unit

`default_nettype wire

// *** verif/capture_compare_unit_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module capture_compare_unit_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_arready,
    input wire logic compare_output,
    input wire logic clear_default_timer,
    input wire logic clear_timer_three,
    input wire logic clear_timer_five,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic [2:0] clrs = {clear_default_timer, clear_timer_three, clear_timer_five};
    wire logic any_clr = |clrs;
    sequence clr_hit; any_clr ##1 !any_clr; endsequence
    clr_onehot_a: assert property ($onehot0(clrs))
        else $error("two timer clears at once");
    clr_pulse_a: assert property (any_clr |-> clr_hit)
        else $error("timer clear longer than one cycle");
    clr_moves_out_a: assert property (any_clr |-> compare_output != $past(compare_output))
        else $error("timer clear without output action");
    out_reset_a: assert property ($rose(aresetn) |-> !compare_output)
        else $error("output high after reset");
    irq_reset_a: assert property ($rose(aresetn) |-> !irq)
        else $error("irq high after reset");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
endmodule : capture_compare_unit_properties
bind capture_compare_unit capture_compare_unit_properties u_props (.*);
`default_nettype wire

// *** verif/capture_compare_unit_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module capture_compare_unit_tb;
    import capture_compare_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, capture_input_pin = 0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, compare_output, irq;
    logic clear_default_timer, clear_timer_three, clear_timer_five;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    timer_value_t tv = 0;
    wire timer_value_t default_timer_value = tv, timer_three_value = tv, timer_five_value = tv;
    int n_fail = 0, checks_done = 0, c[4] = '{default: 0}, b[4];
    logic [7:0] ct[10] = '{8'h88, 8'h89, 8'h82, 8'h82, 8'h88, 8'h08, 8'h88, 8'h80, 8'h8c, 8'h8b};
    logic co[10] = '{1, 0, 1, 0, 1, 0, 1, 0, 0, 0};
    capture_compare_unit u_dut (.*);
    always #50 aclk = ~aclk;
    always @(posedge aclk) c <= '{c[0] + clear_default_timer, c[1] + clear_timer_three,
                                  c[2] + clear_timer_five, c[3] + compare_output};
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        rr = s_axi_bresp;
        s_axi_bready <= 0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        {d, rr} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 0;
        chk(d, e);
    endtask : rdc
    task automatic pin(input logic v);
        @(posedge aclk);
        capture_input_pin <= v;
        repeat (8) @(posedge aclk);
    endtask : pin
    task automatic hit();
        b = c;
        @(posedge aclk);
        tv <= 16'h0300;
        repeat (3) @(posedge aclk);
        tv <= 16'h0301;
        repeat (3) @(posedge aclk);
    endtask : hit
    task automatic end_sim();
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        rdc(8'h04, 32'h55);
        rdc(8'h18, 0);
        chk(rr, 2);
        wr(8'h18, 1);
        chk(rr, 2);
        wr(8'h14, 1);
        chk(rr, 0);
        for (int m = 3; m < 6; m++) begin
            wr(8'h00, 32'h80 | m);
            wr(8'h10, 1);
            tv <= 16'h0200 + m;
            pin(1);
            chk(irq, m != 4);
            wr(8'h10, 1);
            chk(irq, 0);
            pin(0);
            rdc(8'h10, m != 5);
            rdc(8'h08, 32'h200 + m);
        end
        for (int k = 0; k < 2; k++) begin
            wr(8'h00, 32'h86 + k);
            wr(8'h10, 1);
            for (int i = 1; i <= 4 + 12 * k; i++) begin
                pin(1);
                pin(0);
                rdc(8'h10, i == 4 + 12 * k);
            end
        end
        wr(8'h0c, 32'h0300);
        foreach (ct[j]) begin
            wr(8'h00, ct[j]);
            wr(8'h10, 1);
            hit();
            chk(compare_output, co[j]);
            rdc(8'h10, ct[j][7] && ct[j][3:0] != 0);
        end
        chk(c[3] - b[3], 1);
        wr(8'h04, 32'h56);
        wr(8'h00, 32'h8b);
        hit();
        chk(c[1] - b[1], 1);
        wr(8'h04, 32'h57);
        wr(8'h00, 32'h81);
        hit();
        chk(c[2] - b[2], 1);
        chk(c[0], 1);
        chk(compare_output, 1);
        chk(irq, 1);
        wr(8'h14, 0);
        repeat (2) @(posedge aclk);
        chk(irq, 0);
        end_sim();
    end
endmodule : capture_compare_unit_tb
`default_nettype wire
